// ### dv/data_readout_serializer_tb.sv
// Purpose: Self-checking bench for the readout serializer.
// Assumes: Base clock runs faster than 100 kHz so a full burst fits the run.
// Notes: Half period stays above the one-shot so delayed pulses never overlap.
`default_nettype none
module data_readout_serializer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BASE_HALF = 520;
    logic aclk = 1'h0, aresetn = 1'h0, base_clock = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0] wstrb = 4'hF, velocity_sign_bit = 4'h0, full_lock_state = 4'h0, lock_seen;
    logic awready, wready, bvalid, arready, rvalid, store_four_serial = 1'h0;
    logic [1:0] bresp, rresp, rs;
    logic cycle_restart_pulse = 1'h0, word_advance_pulse = 1'h0, time_label_load_cmd = 1'h0;
    logic [3:0] site_id_strobe = 4'h0;
    logic [24:0] velocity_a_n = 25'h0, velocity_b_n = 25'h0, time_label = 25'h0;
    logic [23:0] velocity_c_n = 24'h0, velocity_d_n = 24'h0;
    logic [99:0] site_id_n = 100'h0;
    logic gated_shift_clock, delayed_gated_clock, output_shift_clock, store_one_clock;
    logic store_two_clock, store_three_clock, store_four_clock;
    logic range_extract_window, serial_input_stream_n;
    logic [3:0] channel_range_extract_enable;
    logic [29:0] telemetry_word;
    logic [5:0] pulse_count;
    logic [9:0] slot;
    int fail_count = 0, num_checks = 0, base_cnt = 0;
    data_readout_serializer DUT (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0),
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .base_clock, .cycle_restart_pulse,
        .word_advance_pulse, .time_label_load_cmd, .site_id_strobe, .velocity_a_n,
        .velocity_b_n, .velocity_c_n, .velocity_d_n, .site_id_n, .time_label, .store_four_serial,
        .velocity_sign_bit, .full_lock_state, .gated_shift_clock, .delayed_gated_clock,
        .output_shift_clock, .store_one_clock, .store_two_clock, .store_three_clock,
        .store_four_clock, .range_extract_window, .serial_input_stream_n,
        .channel_range_extract_enable, .telemetry_word);
    pulse_tally tally (.aclk, .aresetn, .gated_shift_clock, .clear(cycle_restart_pulse),
        .pulse_count);
    // Clock and a base clock toggled on aclk edges
    always #2 aclk = ~aclk;
    always @(posedge aclk) begin
        base_cnt <= (base_cnt == BASE_HALF - 1) ? 0 : base_cnt + 1;
        if (base_cnt == BASE_HALF - 1) base_clock <= ~base_clock;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude();
        if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude
    // Expected inverted lock and word identity bits for a slot
    function automatic logic [4:0] exp_top(input logic [9:0] t, input logic [3:0] lk);
        logic l;
        l = (|(t & readout_pkg::SLOTS_LOCK_A) & lk[0]) | (|(t & readout_pkg::SLOTS_LOCK_B) & lk[1])
            | (|(t & readout_pkg::SLOTS_LOCK_C) & lk[2]) | (|(t & readout_pkg::SLOTS_LOCK_D) & lk[3]);
        return ~{l, |(t & readout_pkg::SLOTS_ID28), |(t & readout_pkg::SLOTS_ID27),
            |(t & readout_pkg::SLOTS_ID26), |(t & readout_pkg::SLOTS_ID25)};
    endfunction : exp_top
    // Handshakes are judged at the rising edge; an edge first keeps back-to-back calls apart
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic b_t;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
        b_t = 1'h0;
        while (!b_t) begin
            @(posedge aclk);
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
            b_t = bvalid === 1'h1; r = bresp;
        end
        bready <= 1'h0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic r_t;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'h1; rready <= 1'h1; r_t = 1'h0;
        while (!r_t) begin
            @(posedge aclk);
            if (arready === 1'h1) arvalid <= 1'h0;
            r_t = rvalid === 1'h1; d = rdata; r = rresp;
        end
        rready <= 1'h0;
    endtask : axi_rd
    // One-cycle restart or advance pulse, then let the slot settle
    task automatic step(input logic restart);
        if (restart) cycle_restart_pulse <= 1'h1;
        else word_advance_pulse <= 1'h1;
        @(posedge aclk);
        cycle_restart_pulse <= 1'h0; word_advance_pulse <= 1'h0;
        repeat (3) @(posedge aclk);
    endtask : step
    task automatic check_top(input logic [9:0] t);
        logic [6:0] lines;
        @(negedge aclk);
        chk({27'h0, telemetry_word[29:25]}, {27'h0, exp_top(t, lock_seen)});
        chk({31'h0, gated_shift_clock}, 32'h1);
        lines = {range_extract_window, delayed_gated_clock, output_shift_clock,
                 channel_range_extract_enable};
        chk({25'h0, lines}, {25'h0, 2'h3, |t[8:0], 4'h0});
        @(posedge aclk);
    endtask : check_top
    // Watchdog well beyond the expected run
    initial begin
        #200us;
        fail_count++;
        conclude();
    end
    initial begin
        void'($urandom(3550));
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        velocity_a_n <= 25'($urandom); velocity_b_n <= 25'($urandom);
        velocity_c_n <= 24'($urandom); velocity_d_n <= 24'($urandom);
        site_id_n <= {4{25'($urandom)}}; time_label <= 25'($urandom);
        store_four_serial <= 1'($urandom); velocity_sign_bit <= 4'($urandom);
        full_lock_state <= 4'($urandom);
        @(posedge aclk);
        @(negedge aclk);
        chk({2'h0, telemetry_word}, 32'h3FFFFFFF);
        @(posedge aclk);
        axi_rd(readout_pkg::CONTROL_OFFSET, rd, rs);
        chk({31'h0, rd[0]}, {31'h0, readout_pkg::CONTROL_RESET});
        axi_rd(8'h10, rd, rs);
        chk({30'h0, rs}, {30'h0, readout_pkg::RESP_DECERR});
        // Walk every slot with bursts blocked, then push past slot ten
        axi_wr(readout_pkg::CONTROL_OFFSET, 32'h0, rs);
        chk({30'h0, rs}, {30'h0, readout_pkg::RESP_OKAY});
        lock_seen = full_lock_state;
        step(1'h1);
        slot = readout_pkg::SLOT_ONE;
        for (int s = 0; s < 11; s++) begin
            time_label_load_cmd <= (s == 2);
            site_id_strobe <= 4'($urandom);
            check_top(slot);
            step(1'h0);
            slot = (slot == readout_pkg::SLOT_TEN) ? slot : slot << 1;
        end
        @(negedge aclk);
        chk({7'h0, telemetry_word[24:0]}, {7'h0, ~velocity_a_n});
        @(posedge aclk);
        axi_rd(readout_pkg::CHANNEL_OFFSET, rd, rs);
        chk({24'h0, rd[7:0]}, {24'h0, lock_seen, velocity_sign_bit});
        axi_rd(readout_pkg::STATUS_OFFSET, rd, rs);
        chk({22'h0, rd[9:0]}, {22'h0, readout_pkg::SLOT_TEN});
        // One full burst in slot one shifts store one into the output register
        axi_wr(readout_pkg::CONTROL_OFFSET, 32'h1, rs);
        step(1'h1);
        repeat (2 * BASE_HALF * 26) @(posedge aclk);
        @(negedge aclk);
        chk({26'h0, pulse_count}, 32'h19);
        chk({7'h0, telemetry_word[24:0]}, {7'h0, ~velocity_b_n});
        @(posedge aclk);
        check_top(readout_pkg::SLOT_ONE);
        conclude();
    end
endmodule : data_readout_serializer_tb
`default_nettype wire

// ### dv/pulse_tally.sv
// Purpose: Far-side tally of gated shift clock pulses seen by telemetry.
// Assumes: Gated line is a level sampled on aclk.
// Notes: The tally is cleared only by reset or a cycle restart, so bursts opened by word advance pulses add to it.
`default_nettype none
module pulse_tally (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Observed lines
    input wire logic gated_shift_clock,
    input wire logic clear,
    output logic [5:0] pulse_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_reg;
    // Count rising edges, one per serial data bit
    always_ff @(posedge aclk) begin
        last_reg <= gated_shift_clock;
        if (!aresetn || clear) begin
            pulse_count <= 6'h00;
        end else if (gated_shift_clock && !last_reg) begin
            pulse_count <= pulse_count + 6'h01;
        end
    end
endmodule : pulse_tally
`default_nettype wire

// ### logic/data_readout_serializer.sv
// Purpose: Serializes one readout word per word slot and drives it to telemetry.
// Assumes: All inputs synchronous to aclk; complemented data inputs stay stable while loaded.
// Notes: Gated clocks are modelled as levels plus internal edge events on aclk.
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`default_nettype none
module data_readout_serializer (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite register port
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Timing inputs
    input wire logic base_clock,
    input wire logic cycle_restart_pulse,
    input wire logic word_advance_pulse,
    input wire logic time_label_load_cmd,
    input wire logic [3:0] site_id_strobe,
    // Data inputs, complemented unless noted
    input wire logic [24:0] velocity_a_n,
    input wire logic [24:0] velocity_b_n,
    input wire logic [23:0] velocity_c_n,
    input wire logic [23:0] velocity_d_n,
    input wire logic [99:0] site_id_n,
    input wire logic [24:0] time_label,
    input wire logic store_four_serial,
    input wire logic [3:0] velocity_sign_bit,
    input wire logic [3:0] full_lock_state,
    // Clock outputs
    output logic gated_shift_clock,
    output logic delayed_gated_clock,
    output logic output_shift_clock,
    output logic store_one_clock,
    output logic store_two_clock,
    output logic store_three_clock,
    output logic store_four_clock,
    // Control logic and telemetry outputs
    output logic range_extract_window,
    output logic serial_input_stream_n,
    output logic [3:0] channel_range_extract_enable,
    output logic [29:0] telemetry_word
);
    function automatic logic in_slots(input logic [9:0] slots, input logic [9:0] mask);
        in_slots = |(slots & mask);
    endfunction : in_slots
    logic [9:0] slot_reg, oneshot_reg;
    logic [4:0] count_reg;
    logic inhibit_reg, base_q_reg, base_qq_reg, window_reg, serial_n_reg, control_reg;
    logic [24:0] out_reg, store1_reg;
    logic [23:0] store2_reg, store3_reg;
    logic [3:0] sign_reg, lock_reg, enable_reg;
    logic [29:0] word_reg;
    // Event decode; burst opens on either sequencing pulse
    wire open_burst = (cycle_restart_pulse | word_advance_pulse) & control_reg;
    wire gated_rise = base_q_reg & ~base_qq_reg & ~inhibit_reg;
    wire oneshot_end = (oneshot_reg == 10'h001);
    wire out_shift = gated_rise & in_slots(slot_reg, readout_pkg::SLOTS_OUT);
    wire s1_shift = oneshot_end & in_slots(slot_reg, readout_pkg::SLOTS_S1);
    wire s2_shift = oneshot_end & in_slots(slot_reg, readout_pkg::SLOTS_S2);
    wire s3_shift = oneshot_end & in_slots(slot_reg, readout_pkg::SLOTS_S3);
    wire slot_ten = slot_reg[9];
    wire [3:0] sid_hit = site_id_strobe & {4{slot_reg[3]}};
    wire s1_load = time_label_load_cmd | slot_ten | (|sid_hit);
    wire window_low = (count_reg >= readout_pkg::WINDOW_OPEN) &&
                      (count_reg < readout_pkg::WINDOW_CLOSE);

    // Serial source select by slot, internal data is complemented
    wire ds = (in_slots(slot_reg, readout_pkg::SLOTS_S1) & store1_reg[0]) |
              (in_slots(slot_reg, readout_pkg::SLOTS_S2) & store2_reg[0]) |
              (in_slots(slot_reg, readout_pkg::SLOTS_S3) & store3_reg[0]) |
              (in_slots(slot_reg, readout_pkg::SLOTS_S4) & store_four_serial);

    // Store one load source; the time label is inverted to match the others
    logic [24:0] sid_sel;
    always_comb begin
        sid_sel = '0;
        for (int c = 0; c < readout_pkg::CHANNELS; c++) begin
            if (sid_hit[c]) begin
                sid_sel = site_id_n[c*25 +: 25];
            end
        end
    end
    wire [24:0] s1_data = time_label_load_cmd ? ~time_label :
                          (slot_ten ? velocity_b_n : sid_sel);

    // Word identity and lock bits, held complemented
    wire [3:0] id_bits = {in_slots(slot_reg, readout_pkg::SLOTS_ID28),
                          in_slots(slot_reg, readout_pkg::SLOTS_ID27),
                          in_slots(slot_reg, readout_pkg::SLOTS_ID26),
                          in_slots(slot_reg, readout_pkg::SLOTS_ID25)};
    wire lock_bit = (in_slots(slot_reg, readout_pkg::SLOTS_LOCK_A) & lock_reg[0]) |
                    (in_slots(slot_reg, readout_pkg::SLOTS_LOCK_B) & lock_reg[1]) |
                    (in_slots(slot_reg, readout_pkg::SLOTS_LOCK_C) & lock_reg[2]) |
                    (in_slots(slot_reg, readout_pkg::SLOTS_LOCK_D) & lock_reg[3]);

    // Clock lines; gated and delayed clocks idle high while inhibited, slot-gated clocks low outside their slots
    assign gated_shift_clock = inhibit_reg | base_q_reg;
    assign delayed_gated_clock = (oneshot_reg == 10'h000);
    assign output_shift_clock = gated_shift_clock & in_slots(slot_reg, readout_pkg::SLOTS_OUT);
    assign store_one_clock = delayed_gated_clock & in_slots(slot_reg, readout_pkg::SLOTS_S1);
    assign store_two_clock = delayed_gated_clock & in_slots(slot_reg, readout_pkg::SLOTS_S2);
    assign store_three_clock = delayed_gated_clock & in_slots(slot_reg, readout_pkg::SLOTS_S3);
    assign store_four_clock = delayed_gated_clock & in_slots(slot_reg, readout_pkg::SLOTS_S4);
    assign range_extract_window = window_reg;
    assign serial_input_stream_n = serial_n_reg;
    assign channel_range_extract_enable = enable_reg;
    assign telemetry_word = word_reg;

    // Word slot one-hot sequencer; slot ten holds until restart
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slot_reg <= '0;
        end else if (cycle_restart_pulse) begin
            slot_reg <= readout_pkg::SLOT_ONE;
        end else if (word_advance_pulse && !slot_ten) begin
            slot_reg <= {slot_reg[8:0], 1'b0};
        end
    end

    // Base clock sampling and burst gate
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            base_q_reg <= 1'b1;
            base_qq_reg <= 1'b1;
            inhibit_reg <= 1'b1;
            count_reg <= '0;
        end else begin
            base_q_reg <= base_clock;
            base_qq_reg <= base_q_reg;
            if (open_burst) begin
                inhibit_reg <= 1'b0;
                count_reg <= '0;
            end else if (gated_rise) begin
                count_reg <= count_reg + 5'h01;
                inhibit_reg <= (count_reg + 5'h01 == readout_pkg::BURST_LEN);
            end
        end
    end

    // One-shot restarted by each gated pulse; its end is the store shift edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oneshot_reg <= '0;
        end else if (gated_rise) begin
            oneshot_reg <= readout_pkg::ONESHOT_LOAD;
        end else if (oneshot_reg != 10'h000) begin
            oneshot_reg <= oneshot_reg - 10'h001;
        end
    end

    // Output register: parallel in slot ten, serial in slots one to nine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_reg <= '0;
        end else if (slot_ten) begin
            out_reg <= velocity_a_n;
        end else if (out_shift) begin
            out_reg <= {ds, out_reg[24:1]};
        end
    end

    // Store one: load wins over shift so a moving time label is tracked
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            store1_reg <= '1;
        end else if (s1_load) begin
            store1_reg <= s1_data;
        end else if (s1_shift) begin
            store1_reg <= {1'b1, store1_reg[24:1]};
        end
    end

    // Stores two and three only set ones; the shift-out clears them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            store2_reg <= '0;
            store3_reg <= '0;
        end else begin
            if (slot_ten) begin
                store2_reg <= store2_reg | velocity_c_n;
            end else if (s2_shift) begin
                store2_reg <= {1'b0, store2_reg[23:1]};
            end
            if (slot_ten) begin
                store3_reg <= store3_reg | velocity_d_n;
            end else if (s3_shift) begin
                store3_reg <= {1'b0, store3_reg[23:1]};
            end
        end
    end

    // Captured sign and lock state, window and telemetry outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sign_reg <= '0;
            lock_reg <= '0;
            window_reg <= 1'b1;
            serial_n_reg <= 1'b1;
            word_reg <= '1;
        end else begin
            if (slot_ten) begin
                sign_reg <= velocity_sign_bit;
            end
            if (cycle_restart_pulse) begin
                lock_reg <= full_lock_state;
            end
            window_reg <= ~window_low;
            serial_n_reg <= ~ds;
            word_reg <= ~{lock_bit, id_bits, out_reg};
        end
    end

    // Extract enables; range words of A, B, C, D sit in slots 7, 8, 9, 4
    localparam logic [39:0] CHAN_SLOT = {10'h008, 10'h100, 10'h080, 10'h040};
    for (genvar c = 0; c < 4; c++) begin : g_chan
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                enable_reg[c] <= 1'b0;
            end else begin
                enable_reg[c] <= in_slots(slot_reg, CHAN_SLOT[c*10 +: 10]) &
                                 ~sign_reg[c] & window_low;
            end
        end
    end

    // AXI4-Lite slave: address and data are taken in either order
    logic aw_held_reg, w_held_reg;
    logic [7:0] waddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    assign awready = ~aw_held_reg & ~bvalid;
    assign wready = ~w_held_reg & ~bvalid;
    assign arready = ~rvalid;
    wire write_go = aw_held_reg & w_held_reg & ~bvalid;
    wire wmapped = (waddr_reg == readout_pkg::CONTROL_OFFSET) ||
                   (waddr_reg == readout_pkg::STATUS_OFFSET) ||
                   (waddr_reg == readout_pkg::CHANNEL_OFFSET) ||
                   (waddr_reg == readout_pkg::WORD_OFFSET);
    wire [7:0] raddr = {araddr[7:2], 2'b00};
    wire rmapped = (raddr <= readout_pkg::WORD_OFFSET);
    wire [31:0] status_word = {15'h0000, window_reg, inhibit_reg, count_reg, slot_reg};
    wire [31:0] read_word = (raddr == readout_pkg::CONTROL_OFFSET) ? {31'h0, control_reg} :
                            (raddr == readout_pkg::STATUS_OFFSET) ? status_word :
                            (raddr == readout_pkg::CHANNEL_OFFSET) ?
                                {24'h000000, lock_reg, sign_reg} :
                            {2'b00, word_reg};

    // Write path; the response follows once both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            waddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
            bvalid <= 1'b0;
            bresp <= readout_pkg::RESP_OKAY;
            control_reg <= readout_pkg::CONTROL_RESET;
        end else begin
            if (awvalid && awready) begin
                aw_held_reg <= 1'b1;
                waddr_reg <= {awaddr[7:2], 2'b00};
            end
            if (wvalid && wready) begin
                w_held_reg <= 1'b1;
                wdata_reg <= wdata;
                wstrb_reg <= wstrb;
            end
            if (write_go) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wmapped ? readout_pkg::RESP_OKAY : readout_pkg::RESP_DECERR;
                if (waddr_reg == readout_pkg::CONTROL_OFFSET && wstrb_reg[0]) begin
                    control_reg <= wdata_reg[0];
                end
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Read path, one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= readout_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rmapped ? read_word : 32'h00000000;
            rresp <= rmapped ? readout_pkg::RESP_OKAY : readout_pkg::RESP_DECERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
    // Checks on the burst, clock and word logic
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence burst_open;
        open_burst ##1 (!inhibit_reg && count_reg == 5'h00);
    endsequence
    sequence last_pulse;
        gated_rise && !open_burst && count_reg == 5'h18;
    endsequence
    a_burst_opens: assert property (open_burst |-> burst_open)
        else $error("burst did not open with cleared count");
    a_count_clear: assert property (open_burst |=> count_reg == 5'h00)
        else $error("burst counter not cleared");
    a_burst_stop: assert property (last_pulse |=> inhibit_reg && count_reg == 5'h19)
        else $error("burst did not stop at 25");
    a_count_bound: assert property (count_reg <= 5'h19)
        else $error("burst counter above 25");
    a_idle_high: assert property (inhibit_reg |-> gated_shift_clock)
        else $error("gated clock low while inhibited");
    a_oneshot_low: assert property (gated_rise ##1 !gated_rise |-> ##[1:2] !delayed_gated_clock)
        else $error("delayed clock did not drop");
    a_oneshot_end: assert property (oneshot_reg == 10'h001 |=> delayed_gated_clock)
        else $error("delayed clock did not return high");
    a_no_out_clk: assert property (slot_ten |-> !output_shift_clock)
        else $error("output shift clock in slot ten");
    a_s1_clock: assert property (store_one_clock |-> in_slots(slot_reg, 10'h031))
        else $error("store one clock outside its slots");
    a_window_low: assert property (count_reg == 5'h13 |=> !range_extract_window)
        else $error("window not low at count 19");
    a_window_high: assert property (count_reg == 5'h18 |=> range_extract_window)
        else $error("window not high at count 24");
    a_sign_grab: assert property (slot_ten |=> sign_reg == $past(velocity_sign_bit))
        else $error("sign bits not captured");
    a_enable_gate: assert property (|enable_reg |-> $past(window_low))
        else $error("extract enable outside window");
    a_par_load: assert property (slot_ten |=> out_reg == $past(velocity_a_n))
        else $error("parallel load missed");
    a_word_id: assert property (slot_ten [*2] |=> telemetry_word[28:25] == 4'h6)
        else $error("slot ten identity code wrong");
    a_output_inv: assert property (##1 telemetry_word[24:0] == ~$past(out_reg))
        else $error("output not inverted");
    a_s1_load: assert property (time_label_load_cmd |=> store1_reg == ~$past(time_label))
        else $error("time label load missed");
    a_s2_setonly: assert property (slot_ten |=> (store2_reg & $past(store2_reg)) == $past(store2_reg))
        else $error("store two lost a one on load");
    a_slot_seed: assert property (cycle_restart_pulse |=> slot_reg == 10'h001)
        else $error("slot register not seeded");
    a_slot_hold: assert property (slot_ten && !cycle_restart_pulse |=> slot_ten)
        else $error("slot ten not held");
endmodule : data_readout_serializer
`default_nettype wire

// ### logic/readout_pkg.sv
// Purpose: Shared constants for the data readout serializer.
// Assumes: 250 MHz aclk, 100 kHz base clock sampled as a synchronous input.
// Notes: Offsets are byte addresses on the AXI4-Lite register port.
//
// Behaviour
// - Emit a burst of exactly 25 gated pulses at each word slot start.
// - Cycle restart or word advance pulse lowers burst inhibit, opening the gate.
// - Five-stage counter counts gated pulses; at count 25 inhibit is raised.
// - Gated shift clock rests at one while bursts are inhibited.
// - Delayed gated clock is an inverted 2 us one-shot fired by each pulse.
// - Output register clock is gated clock ANDed with slots one to nine.
// - Store clocks are delayed clock ANDed with their slot terms.
// - Counter decodes counts 19 and 24; window enable is zero between them.
// - Capture the four velocity sign bits in slot ten; zero means negative.
// - Per channel give delayed clock, inverted serial stream, and extract enable; only the extract enable is per channel here, the other two are single lines.
// - Output register is 25 bits with parallel and serial loading.
// - Slot ten loads complemented first velocity word in parallel, no preset.
// - Serial input selects store by slot: 1,5,6 / 2 / 3 / 4,7,8,9.
// - Bits 25-28 carry the complemented word identity code from slot terms.
// - Bit 29 carries stored lock state per channel in its two slots.
// - All 30 bits are held complemented and inverted at the output.
// - Store one: 25 bits, velocity B, site ID, time label (label true).
// - Store one loads on label command, slot ten, or slot four with strobe.
// - Store one shifts in ones and its load forces both ones and zeros.
// - Stores two and three: 24 bits, shift in zeros, load only sets ones.
// - Ten-stage one-hot slot register: restart seeds, advance shifts, ten holds.
package readout_pkg;
    localparam int WORD_BITS = 25;
    localparam int SHORT_BITS = 24;
    localparam int SLOTS = 10;
    localparam int CHANNELS = 4;
    localparam logic [4:0] BURST_LEN = 5'h19;
    localparam logic [4:0] WINDOW_OPEN = 5'h13;
    localparam logic [4:0] WINDOW_CLOSE = 5'h18;
    localparam int CLK_PERIOD_NS = 4;
    localparam int ONESHOT_NS = 2000;
    localparam int ONESHOT_CYCLES = (ONESHOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0] ONESHOT_LOAD = 10'(ONESHOT_CYCLES);
    // Slot masks, bit n is slot n+1
    localparam logic [9:0] SLOTS_OUT = 10'h1FF;
    localparam logic [9:0] SLOTS_S1 = 10'h031;
    localparam logic [9:0] SLOTS_S2 = 10'h002;
    localparam logic [9:0] SLOTS_S3 = 10'h004;
    localparam logic [9:0] SLOTS_S4 = 10'h1C8;
    localparam logic [9:0] SLOTS_ID28 = 10'h2AA;
    localparam logic [9:0] SLOTS_ID27 = 10'h0CC;
    localparam logic [9:0] SLOTS_ID26 = 10'h0F0;
    localparam logic [9:0] SLOTS_ID25 = 10'h300;
    localparam logic [9:0] SLOTS_LOCK_A = 10'h240;
    localparam logic [9:0] SLOTS_LOCK_B = 10'h081;
    localparam logic [9:0] SLOTS_LOCK_C = 10'h102;
    localparam logic [9:0] SLOTS_LOCK_D = 10'h00C;
    localparam logic [9:0] SLOT_ONE = 10'h001;
    localparam logic [9:0] SLOT_TEN = 10'h200;
    // Register map
    localparam logic [7:0] CONTROL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] CHANNEL_OFFSET = 8'h08;
    localparam logic [7:0] WORD_OFFSET = 8'h0C;
    localparam logic CONTROL_RESET = 1'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : readout_pkg
